// ---- gptu_cfg.svh ----
/*
 * Register offsets, field positions, reset values and prescaler bases
 * of the general purpose timer unit.
 * Assumes byte addresses on an AXI4-Lite bus with 32-bit words.
 */
`ifndef GPTU_CFG_SVH
`define GPTU_CFG_SVH

// Timer control words, one per timer, index i at CTL0 + 4*i
`define GPTU_CTL0        8'h00
// Capture and reload control of the second module
`define GPTU_CAPCTL      8'h14
// Timer count values, index i at CNT0 + 4*i
`define GPTU_CNT0        8'h20
`define GPTU_CAPTURE_RELOAD_REG      8'h34
// Sticky request flags, write one to clear
`define GPTU_FLAGS       8'h38

// Timer control fields
`define GPTU_F_PS        0
`define GPTU_F_MODE      3
`define GPTU_F_RUN       5
`define GPTU_F_DOWN      6
`define GPTU_F_EXTDIR    7
`define GPTU_F_EDGE      8
`define GPTU_F_GPOL      10
`define GPTU_F_AUXFN     11
`define GPTU_F_RLTRG     13

// Capture control fields
`define GPTU_C_PINEDGE   0
`define GPTU_C_INEDGE    2
`define GPTU_C_DIREDGE   4
`define GPTU_C_CLR       6
`define GPTU_C_T6RL      7

// Flag bits: 0..4 timer wrap, 5 capture
`define GPTU_FL_CAP      5

// Prescaler base shift: module one 4 cycles, module two 2 cycles
`define GPTU_BASE_ONE    4'h2
`define GPTU_BASE_TWO    4'h1

`define GPTU_CTL_RST     16'h0000
`define GPTU_CNT_RST     16'h0000

`endif

// ---- gptu_pkg.sv ----
/*
 * Types of the general purpose timer unit.
 * Assumes gptu_cfg.svh for all numeric constants.
 */
package gptu_pkg;

  typedef enum logic [1:0] {
    GPTU_TIMER,
    GPTU_GATED,
    GPTU_COUNTER,
    GPTU_INCR
  } gptu_mode_t;

  typedef enum logic [1:0] {
    GPTU_NORMAL,
    GPTU_CAPTURE,
    GPTU_RELOAD,
    GPTU_AUX_RSVD
  } gptu_auxfn_t;

  typedef enum logic [1:0] {
    GPTU_RT_NONE,
    GPTU_RT_TL_RISE,
    GPTU_RT_TL_FALL,
    GPTU_RT_PIN
  } gptu_rltrg_t;

endpackage

// ---- gptu_top.sv ----
/*
 * General purpose timer unit: five 16-bit timers in two modules with
 * an AXI4-Lite register slave.
 * Assumes one clock aclk, synchronous active-low reset, asynchronous pins.
 */
// Design decisions made here: register access over AXI4-Lite and the address map.
// What this block does
// R1: Five 16-bit timers, three plus two-with-register
// R2: Timers run alone or chained within module
// R3: Module one timers: timer, gated, counter, encoder
// R4: Timer mode prescaled clock; counter mode pin events
// R5: Gated mode counts while pin level enables
// R6: Module one finest step four system clocks
// R7: Software direction, optionally flipped by pin
// R8: Encoder mode decodes A/B into count, direction
// R9: Core timer wraps toggle latch; latch clocks aux
// R10: Aux timer stops when capture or reload
// R11: Aux capture copies core timer on pin
// R12: Aux reload loads core on pin or latch
// R13: Alternate reloads on latch edges give PWM
// R14: Module two finest step two clocks
// R15: Second core wraps toggle second latch
// R16: Second core wraps feed compare clock, reload
// R17: Capture pin stores aux c, optional clear
// R18: Capture also on core count/direction inputs
// R19: Wraps and captures set sticky request flags; only the capture register's capture sets one, aux a/b captures set none
// R20: All pins synchronised before edge detection
`timescale 1ns/1ps
`include "gptu_cfg.svh"

module gptu_top #(
  parameter int NT = 5,
  parameter int W  = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [7:0]    awaddr,
  input  wire logic [2:0]    awprot,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [7:0]    araddr,
  input  wire logic [2:0]    arprot,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  input  wire logic [NT-1:0] timer_input_pin,
  input  wire logic [NT-1:0] direction_input_pin,
  input  wire logic          capture_input_pin,
  output logic               core_toggle_out,
  output logic               second_toggle_out,
  output logic               compare_clk_pulse
);

  // Edge selection: 01 rising, 10 falling, 11 both
  function automatic logic edge_hit(input logic [1:0] sel, input logic lvl, input logic e);
    edge_hit = e & ((sel == 2'h1 & lvl) | (sel == 2'h2 & ~lvl) | (sel == 2'h3));
  endfunction

  function automatic logic tick_of(input logic [15:0] pre, input logic [3:0] sh);
    tick_of = (pre & ~(16'hFFFF << sh)) == 16'h0000;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  logic [2*NT:0] s1_q;
  logic [2*NT:0] s2_q;
  logic [2*NT:0] p_q;
  logic [2*NT:0] e;
  logic [15:0]   pre_q;
  logic [15:0]   cnt_w [NT];
  logic [15:0]   ctl_w [NT];
  logic [NT-1:0] ovf;
  logic [NT-1:0] ld;
  logic [15:0]   ldv [NT];
  logic [15:0]   capctl_q;
  logic [15:0]   capture_reload_reg_q;
  logic [5:0]    flags_q;
  logic          core_tl_q;
  logic          t6_tl_q;
  logic          cmp_q;
  logic          aw_got_q;
  logic          w_got_q;
  logic [7:0]    wa_q;
  logic [31:0]   wd_q;
  logic [3:0]    ws_q;
  logic          awready_q;
  logic          wready_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          arready_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;
  logic          wr_go;
  logic [NT-1:0] rl_core;
  logic          cap_ev;
  logic [NT-1:0] tin_s;
  logic [NT-1:0] eud_s;
  logic [NT-1:0] tin_e;
  logic [NT-1:0] eud_e;
  logic [NT-1:0] tl_ev;

  // Two-flop pin synchronisers, third stage for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      p_q  <= '0;
    end else begin
      s1_q <= {capture_input_pin, direction_input_pin, timer_input_pin}; // R20
      s2_q <= s1_q;
      p_q  <= s2_q;
    end
  end

  assign e     = s2_q ^ p_q;
  assign tin_s = s2_q[NT-1:0];
  assign eud_s = s2_q[2*NT-1:NT];
  assign tin_e = e[NT-1:0];
  assign eud_e = e[2*NT-1:NT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // Toggle latch edge seen by each aux timer's counter-mode chaining
  assign tl_ev = {1'b0, ovf[4], ovf[1], 1'b0, ovf[1]}; // R2 R9 R15

  assign wr_go = aw_got_q & w_got_q & ~bvalid_q;

  // Five timers, 0..2 module one, 3..4 module two
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    logic [15:0] ctl_q;
    logic [15:0] cnt_q;
    logic        ev;
    logic        run;
    logic        down;
    logic        wrap;
    gptu_pkg::gptu_mode_t  mode;
    gptu_pkg::gptu_auxfn_t fn;

    assign mode = gptu_pkg::gptu_mode_t'(ctl_q[`GPTU_F_MODE+1:`GPTU_F_MODE]);
    assign fn   = gptu_pkg::gptu_auxfn_t'(ctl_q[`GPTU_F_AUXFN+1:`GPTU_F_AUXFN]);

    always_comb begin
      logic [3:0] sh;
      logic [1:0] es;
      sh   = ((i < 3) ? `GPTU_BASE_ONE : `GPTU_BASE_TWO) + {1'b0, ctl_q[2:0]}; // R6 R14
      es   = ctl_q[`GPTU_F_EDGE+1:`GPTU_F_EDGE];
      down = ctl_q[`GPTU_F_DOWN] ^ (ctl_q[`GPTU_F_EXTDIR] & eud_s[i]); // R7
      case (mode) // R3
        gptu_pkg::GPTU_TIMER: begin
          ev = tick_of(pre_q, sh); // R4
        end
        gptu_pkg::GPTU_GATED: begin
          ev = tick_of(pre_q, sh) & (tin_s[i] == ctl_q[`GPTU_F_GPOL]); // R5
        end
        gptu_pkg::GPTU_COUNTER: begin
          ev = (es == 2'h0) ? tl_ev[i] : edge_hit(es, tin_s[i], tin_e[i]); // R4 R2
        end
        gptu_pkg::GPTU_INCR: begin
          // A edge: up when A differs from B; B edge: up when equal
          ev   = tin_e[i] | eud_e[i]; // R8
          down = tin_e[i] ? (tin_s[i] == eud_s[i]) : (tin_s[i] != eud_s[i]); // R8
        end
        default: begin
          ev = 1'b0;
        end
      endcase
      // Aux timers used as capture or reload registers stand still
      run  = ctl_q[`GPTU_F_RUN] & (fn == gptu_pkg::GPTU_NORMAL || i == 1 || i == 4); // R10
      wrap = ev & run & (down ? (cnt_q == 16'h0000) : (cnt_q == 16'hFFFF));
    end

    assign ovf[i]   = wrap;
    assign cnt_w[i] = cnt_q;
    assign ctl_w[i] = ctl_q;
    assign rl_core[i] = (i == 0 || i == 2) && fn == gptu_pkg::GPTU_RELOAD &&
                        (ctl_q[`GPTU_F_RLTRG+1:`GPTU_F_RLTRG] == 2'h1 ? ovf[1] & ~core_tl_q :
                         ctl_q[`GPTU_F_RLTRG+1:`GPTU_F_RLTRG] == 2'h2 ? ovf[1] & core_tl_q :
                         ctl_q[`GPTU_F_RLTRG+1:`GPTU_F_RLTRG] == 2'h3 ?
                         edge_hit(ctl_q[`GPTU_F_EDGE+1:`GPTU_F_EDGE], tin_s[i], tin_e[i]) :
                         1'b0); // R12 R13

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_q <= `GPTU_CTL_RST;
      end else if (wr_go && wa_q == `GPTU_CTL0 + 8'(4 * i)) begin
        ctl_q <= merge(ctl_q, wd_q, ws_q);
      end
    end

    // Software write, then load, then counting
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q <= `GPTU_CNT_RST;
      end else if (wr_go && wa_q == `GPTU_CNT0 + 8'(4 * i)) begin
        cnt_q <= merge(cnt_q, wd_q, ws_q);
      end else if (ld[i]) begin
        cnt_q <= ldv[i];
      end else if (ev & run) begin
        cnt_q <= down ? cnt_q - 16'h0001 : cnt_q + 16'h0001; // R1
      end
    end
  end

  // Capture trigger of the second module
  assign cap_ev = edge_hit(capctl_q[`GPTU_C_PINEDGE+1:`GPTU_C_PINEDGE],
                           s2_q[2*NT], e[2*NT]) | // R17
                  edge_hit(capctl_q[`GPTU_C_INEDGE+1:`GPTU_C_INEDGE], tin_s[1], tin_e[1]) |
                  edge_hit(capctl_q[`GPTU_C_DIREDGE+1:`GPTU_C_DIREDGE],
                           eud_s[1], eud_e[1]); // R18

  // Loads from capture and reload paths
  always_comb begin
    for (int k = 0; k < NT; k++) begin
      ld[k]  = 1'b0;
      ldv[k] = 16'h0000;
    end
    for (int k = 0; k < 3; k += 2) begin
      if (ctl_w[k][`GPTU_F_AUXFN+1:`GPTU_F_AUXFN] == 2'h1 &&
          edge_hit(ctl_w[k][`GPTU_F_EDGE+1:`GPTU_F_EDGE], tin_s[k], tin_e[k])) begin
        ld[k]  = 1'b1; // R11
        ldv[k] = cnt_w[1];
      end
    end
    if (rl_core[0]) begin
      ld[1]  = 1'b1; // R12
      ldv[1] = cnt_w[0];
    end else if (rl_core[2]) begin
      ld[1]  = 1'b1; // R12
      ldv[1] = cnt_w[2];
    end
    if (cap_ev & capctl_q[`GPTU_C_CLR]) begin
      ld[3] = 1'b1; // R17
    end
    if (ovf[4] & capctl_q[`GPTU_C_T6RL]) begin
      ld[4]  = 1'b1; // R16
      ldv[4] = capture_reload_reg_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reload_reg_q <= 16'h0000;
    end else if (cap_ev) begin
      capture_reload_reg_q <= cnt_w[3]; // R17
    end else if (wr_go && wa_q == `GPTU_CAPTURE_RELOAD_REG) begin
      capture_reload_reg_q <= merge(capture_reload_reg_q, wd_q, ws_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capctl_q <= `GPTU_CTL_RST;
    end else if (wr_go && wa_q == `GPTU_CAPCTL) begin
      capctl_q <= merge(capctl_q, wd_q, ws_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_tl_q <= 1'b0;
      t6_tl_q   <= 1'b0;
      cmp_q     <= 1'b0;
    end else begin
      core_tl_q <= core_tl_q ^ ovf[1]; // R9
      t6_tl_q   <= t6_tl_q ^ ovf[4]; // R15
      cmp_q     <= ovf[4]; // R16
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= (flags_q & ~((wr_go && wa_q == `GPTU_FLAGS && ws_q[0]) ? wd_q[5:0] : 6'h00))
                 | {cap_ev, ovf}; // R19
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      wa_q      <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
    end else begin
      if (awvalid & awready_q) begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        wa_q      <= {awaddr[7:2], 2'h0};
      end
      if (wvalid & wready_q) begin
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
        wd_q     <= wdata;
        ws_q     <= wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wa_q <= `GPTU_CAPCTL || (wa_q >= `GPTU_CNT0 && wa_q <= `GPTU_FLAGS))
                    ? 2'h0 : 2'h2;
      end
      if (bvalid_q & bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end else if (arvalid & arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
      if ({araddr[7:2], 2'h0} < `GPTU_CTL0 + 8'(4 * NT)) begin
        rdata_q <= {16'h0000, ctl_w[araddr[4:2]]};
      end else if ({araddr[7:2], 2'h0} == `GPTU_CAPCTL) begin
        rdata_q <= {16'h0000, capctl_q};
      end else if ({araddr[7:2], 2'h0} >= `GPTU_CNT0 &&
                   {araddr[7:2], 2'h0} < `GPTU_CNT0 + 8'(4 * NT)) begin
        rdata_q <= {16'h0000, cnt_w[araddr[4:2]]};
      end else if ({araddr[7:2], 2'h0} == `GPTU_CAPTURE_RELOAD_REG) begin
        rdata_q <= {16'h0000, capture_reload_reg_q};
      end else if ({araddr[7:2], 2'h0} == `GPTU_FLAGS) begin
        rdata_q <= {26'h0, flags_q};
      end else begin
        rresp_q <= 2'h2;
      end
    end else if (rvalid_q & rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready           = awready_q;
  assign wready            = wready_q;
  assign bvalid            = bvalid_q;
  assign bresp             = bresp_q;
  assign arready           = arready_q;
  assign rvalid            = rvalid_q;
  assign rdata             = rdata_q;
  assign rresp             = rresp_q;
  assign core_toggle_out   = core_tl_q;
  assign second_toggle_out = t6_tl_q;
  assign compare_clk_pulse = cmp_q;

endmodule

// ---- gptu_properties.sv ----
/* Checker of the timer unit's bus answers and event outputs.
   Sees only top-level ports; bound from the bench. */
`timescale 1ns/1ps
module gptu_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        second_toggle_out,
  input wire logic        compare_clk_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_ans;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_blk;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_blk: assert property (p_b_blk) else $error("write taken while busy");
  property p_rd_ans;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data unstable");
  property p_unmap;
    arvalid && arready && araddr > 8'h3B |=> rresp == 2'h2 && rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_width;
    rvalid |-> rdata[31:16] == 16'h0;
  endproperty
  a_width: assert property (p_width) else $error("upper data bits set");
  property p_pulse;
    $changed(second_toggle_out) |-> ##[0:2] compare_clk_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wrap without pulse");
  property p_one;
    compare_clk_pulse |=> !compare_clk_pulse;
  endproperty
  a_one: assert property (p_one) else $error("pulse too long");
endmodule

// ---- gptu_pins.sv ----
/* Pin-side stand-in: pulse trains on one timer or capture pin.
   Expects one go cycle while idle; timer and capture lines idle low, direction lines follow dir_lvl. */
`timescale 1ns/1ps
module gptu_pins_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [2:0] sel,
  input  wire logic [3:0] num,
  input  wire logic       dir_lvl,
  output logic [4:0]      timer_input_pin,
  output logic [4:0]      direction_input_pin,
  output logic            capture_input_pin,
  output logic            busy
);
  assign direction_input_pin = {5{dir_lvl}};
  task drive(input logic v);
    if (sel == 3'h5) capture_input_pin <= v;
    else timer_input_pin[sel] <= v;
  endtask
  initial begin
    timer_input_pin = 5'h00;
    capture_input_pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        // Levels outlast the input synchroniser
        repeat (num) begin
          repeat (4) @(posedge aclk);
          drive(1'b1);
          repeat (4) @(posedge aclk);
          drive(1'b0);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- test_general_purpose_timer_unit.sv ----
/* Self-checking bench of the timer unit.
   Drives the register bus and the pin model; checker bound at foot. */
`timescale 1ns/1ps
`include "gptu_cfg.svh"
module test_general_purpose_timer_unit;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  tin, din;
  logic        cap, tg1, tg2, cmp, go, dl, busy;
  logic [2:0]  sel;
  logic [3:0]  num;
  int          errors, check_count, t0, v;
  int          cyc = 0;
  int          pulses = 0;
  gptu_top gptu_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timer_input_pin(tin), .direction_input_pin(din), .capture_input_pin(cap),
    .core_toggle_out(tg1), .second_toggle_out(tg2), .compare_clk_pulse(cmp));
  gptu_pins_model gptu_pins_model_inst (.aclk(aclk), .go(go), .sel(sel),
    .num(num), .dir_lvl(dl), .timer_input_pin(tin), .direction_input_pin(din),
    .capture_input_pin(cap), .busy(busy));
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cmp === 1'b1) pulses <= pulses + 1;
  end
  task automatic chk(input logic [35:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int k);
    if (k > 200) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    logic [2:0] s;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      tick(k++);
      s = {awready, wready, bvalid};
      if (s[0]) rs = bresp;
      @(posedge aclk);
      if (s[2]) awvalid <= 1'b0;
      if (s[1]) wvalid <= 1'b0;
      if (s[0]) bready <= 1'b0;
    end while (!s[0]);
  endtask
  task automatic rdr(input logic [7:0] a);
    int k = 0;
    logic [1:0] s;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      tick(k++);
      s = {arready, rvalid};
      if (s[0]) begin
        rd = rdata;
        rs = rresp;
      end
      @(posedge aclk);
      if (s[1]) arvalid <= 1'b0;
      if (s[0]) rready <= 1'b0;
    end while (!s[0]);
  endtask
  task automatic pulse(input int s, c);
    int k = 0;
    sel <= 3'(s);
    num <= 4'(c);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(negedge aclk);
      tick(k++);
    end while (busy);
    repeat (8) @(posedge aclk);
  endtask
  function automatic logic [7:0] ctl(input int i);
    return 8'(`GPTU_CTL0 + 4 * i);
  endfunction
  function automatic logic [7:0] cnt(input int i);
    return 8'(`GPTU_CNT0 + 4 * i);
  endfunction
  function automatic logic [31:0] cw(input int ps, md, dn, xd, ed);
    return 32'(ps << `GPTU_F_PS | md << `GPTU_F_MODE | 1 << `GPTU_F_RUN
      | dn << `GPTU_F_DOWN | xd << `GPTU_F_EXTDIR | ed << `GPTU_F_EDGE);
  endfunction
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, go, dl} = 7'h00;
    {awaddr, araddr, wdata, sel, num} = 55'h0;
    {errors, check_count} = 64'h0;
    aresetn = 1'b0;
    v = $urandom(10005);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdr(ctl(i));
      chk(rd, `GPTU_CTL_RST, "ctl reset");
      rdr(cnt(i));
      chk(rd, `GPTU_CNT_RST, "cnt reset");
      v = $urandom;
      wr(cnt(i), v);
      rdr(cnt(i));
      chk(rd, {16'h0, v[15:0]}, "cnt width");
    end
    wr(8'h3C, 32'h1);
    chk(rs, 2'h2, "unmapped write");
    rdr(8'h3C);
    chk({rs, rd}, {2'h2, 32'h0}, "unmapped read");
    $display("bus test done");
    for (int j = 0; j < 2; j++) begin
      int i, ps, per;
      i = j ? 4 : 1;
      ps = $urandom % 3;
      per = (1 << (j ? `GPTU_BASE_TWO : `GPTU_BASE_ONE)) << ps;
      wr(cnt(i), 0);
      wr(ctl(i), cw(ps, 0, 0, 0, 0));
      t0 = cyc;
      repeat (300) @(posedge aclk);
      wr(ctl(i), 0);
      v = (cyc - t0) / per;
      rdr(cnt(i));
      chk(rd + 2 >= v && rd <= v + 2, 1, "prescaled rate");
    end
    $display("rate test done");
    // Aux a counts core latch wraps
    wr(cnt(0), 0);
    wr(ctl(0), cw(0, 2, 0, 0, 0));
    for (int j = 0; j < 2; j++) begin
      int i;
      i = j ? 4 : 1;
      wr(cnt(i), 2);
      wr(ctl(i), cw(0, 0, 1, 0, 0));
      repeat (40) @(posedge aclk);
      wr(ctl(i), 0);
      chk(j ? tg2 : tg1, 1, "toggle latch");
      rdr(cnt(i));
      chk(rd[15:8], 8'hFF, "down wrap");
      rdr(`GPTU_FLAGS);
      chk(rd[i], 1, "wrap flag");
      wr(`GPTU_FLAGS, 32'h3F);
      rdr(`GPTU_FLAGS);
      chk(rd, 0, "flag clear");
    end
    chk(pulses, 1, "compare pulses");
    rdr(cnt(0));
    chk(rd, 1, "chained count");
    $display("wrap test done");
    for (int j = 0; j < 4; j++) begin
      int c;
      c = 1 + $urandom % 8;
      dl <= j[0];
      wr(cnt(0), 100);
      wr(ctl(0), cw(0, int'(gptu_pkg::GPTU_COUNTER), 0, 1, 1));
      pulse(0, c);
      wr(ctl(0), 0);
      rdr(cnt(0));
      chk(rd, j[0] ? 100 - c : 100 + c, "event count");
    end
    // Gate high four cycles per pulse: one step each
    wr(cnt(1), 0);
    wr(ctl(1), cw(0, 1, 0, 0, 0) | 1 << `GPTU_F_GPOL);
    v = 1 + $urandom % 8;
    pulse(1, v);
    wr(ctl(1), 0);
    rdr(cnt(1));
    chk(rd, v, "gated count");
    // Forward quadrature: A up, B up, A down, B down
    dl <= 1'b0;
    wr(cnt(2), 100);
    wr(ctl(2), cw(0, 3, 0, 0, 0));
    fork
      pulse(2, 1);
      begin
        repeat (6) @(posedge aclk);
        dl <= 1'b1;
      end
    join
    dl <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(ctl(2), 0);
    rdr(cnt(2));
    chk(rd, 100 + 4, "encoder count");
    // Aux a captures the core and then stands still
    wr(cnt(0), 0);
    wr(cnt(1), 0);
    wr(ctl(0), cw(0, 0, 0, 0, 1) | 1 << `GPTU_F_AUXFN);
    wr(ctl(1), cw(0, 0, 0, 0, 0));
    pulse(0, 1);
    rdr(cnt(0));
    v = rd;
    repeat (40) @(posedge aclk);
    rdr(cnt(0));
    chk(rd == v && v > 0, 1, "aux capture");
    wr(ctl(1), 0);
    // Aux a reloads the stopped core on its pin
    wr(cnt(0), 32'h0000_AB00);
    wr(ctl(0), 32'(1 << `GPTU_F_EDGE | 2 << `GPTU_F_AUXFN | 3 << `GPTU_F_RLTRG));
    pulse(0, 1);
    wr(ctl(0), 0);
    rdr(cnt(1));
    chk(rd, 32'h0000_AB00, "pin reload");
    $display("counter test done");
    for (int j = 0; j < 2; j++) begin
      wr(`GPTU_CAPCTL, 32'(1 << (j ? `GPTU_C_INEDGE : `GPTU_C_PINEDGE)
        | 1 << `GPTU_C_CLR));
      wr(cnt(3), 0);
      wr(ctl(3), cw(0, 0, 0, 0, 0));
      repeat (60) @(posedge aclk);
      pulse(j ? 1 : 5, 1);
      wr(ctl(3), 0);
      rdr(`GPTU_CAPTURE_RELOAD_REG);
      v = rd;
      rdr(cnt(3));
      chk(v > 20 && rd < v, 1, "capture clear");
      rdr(`GPTU_FLAGS);
      chk(rd[`GPTU_FL_CAP], 1, "capture flag");
      wr(`GPTU_FLAGS, 32'h3F);
    end
    // Core two wrap reloads it from the capture register
    wr(`GPTU_CAPTURE_RELOAD_REG, 32'h0000_FF00);
    wr(`GPTU_CAPCTL, 32'(1 << `GPTU_C_T6RL));
    wr(cnt(4), 32'h0000_FFFE);
    wr(ctl(4), cw(0, 0, 0, 0, 0));
    repeat (40) @(posedge aclk);
    wr(ctl(4), 0);
    rdr(cnt(4));
    chk(rd[15:8], 8'hFF, "reload from capture reg");
    $display("capture test done");
    wrap_up();
  end
endmodule
bind gptu_top gptu_chk gptu_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .second_toggle_out(second_toggle_out),
  .compare_clk_pulse(compare_clk_pulse));
